/* File: hw/branch_compare_skip_unit.sv */
// compare, skip, conditional branch and call/return sequencing for an 8-bit core
// assumes the decoder presents operands, the current pc and the addressed i/o
// byte together with the issue strobe, and that the stack answers a pop in the
// same cycle the pop strobe is high
`timescale 1ns/10ps

module branch_compare_skip_unit
#(
  parameter int unsigned PC_W = 16
)
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // issue from the instruction decoder
  input wire logic issue,
  input wire flow_pkg::flow_op_t op,
  input wire logic [PC_W-1:0] pc,
  input wire logic [flow_pkg::DATA_W-1:0] rd_val,
  input wire logic [flow_pkg::DATA_W-1:0] rr_val,
  input wire logic [flow_pkg::DATA_W-1:0] io_val,
  input wire logic [flow_pkg::BIT_SEL_W-1:0] bit_sel,
  input wire logic [flow_pkg::OFFSET_W-1:0] offset,
  input wire logic [PC_W-1:0] target,
  input wire logic next_two_word,
  // status byte as held by the core
  input wire logic [7:0] status_flags_register,
  // stack port
  input wire logic [PC_W-1:0] pop_data,
  // results
  output logic busy,
  output logic done,
  output logic pc_load,
  output logic [PC_W-1:0] next_pc,
  output logic flags_wr,
  output logic [7:0] flags_mask,
  output logic [7:0] flags_out,
  output logic push,
  output logic [PC_W-1:0] push_data,
  output logic pop
);
  import flow_pkg::*;

  // a narrower pc cannot hold the relative offset range; refused at elaboration
  if (PC_W < OFFSET_W + 1 || PC_W > 32)
  begin
    $error("PC_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // relative target pc + k + 1 with k sign-extended
  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] base,
                                                 input logic [OFFSET_W-1:0] k);
    logic [PC_W-1:0] ext;
    ext = {{(PC_W-OFFSET_W){k[OFFSET_W-1]}}, k};
    rel_target = base + ext + PC_W'(PC_STEP_NEXT);
  endfunction

  // skip destination: past a one-word or two-word instruction
  function automatic logic [PC_W-1:0] skip_target(input logic [PC_W-1:0] base,
                                                  input logic two_word);
    skip_target = two_word ? base + PC_W'(PC_STEP_SKIP2) : base + PC_W'(PC_STEP_SKIP1);
  endfunction

  // subtract without storing, returning the compare flags in status layout
  function automatic logic [7:0] cmp_flags(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic cin,
                                           input logic chain_z,
                                           input logic z_old);
    logic [7:0] r;
    logic [7:0] f;
    r = a - b - {7'h00, cin};
    f = FLAGS_RESET;
    f[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    f[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[FLAG_N] = r[7];
    f[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    // the carry-chained form keeps zero only if every byte so far was zero
    f[FLAG_Z] = (r == 8'h00) & (~chain_z | z_old);
    cmp_flags = f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // instruction evaluation at issue

  logic take;
  logic is_skip;
  logic is_branch;
  logic is_cmp;
  logic [2:0] cycles;
  logic [PC_W-1:0] dest;
  logic [7:0] cmp_res;
  logic [7:0] sf;

  // decide outcome, skip/branch/compare class and compare flags in the issue cycle
  always_comb
  begin
    sf = status_flags_register;
    take = 1'b0;
    is_skip = 1'b0;
    is_branch = op inside {op_branch_flag_set, op_branch_flag_clear, op_branch_equal, op_branch_carry_clear,
      op_branch_same_or_higher, op_branch_minus, op_branch_signed_ge, op_branch_signed_lt,
      op_branch_halfcarry_set, op_branch_halfcarry_clear, op_branch_bitcopy_set};
    is_cmp = 1'b0;
    cmp_res = FLAGS_RESET;
    unique case (op)
      op_compare_skip_equal:
      begin
        is_skip = 1'b1;
        take = (rd_val == rr_val);
      end
      op_compare_regs:
      begin
        is_cmp = 1'b1;
        cmp_res = cmp_flags(rd_val, rr_val, 1'b0, 1'b0, sf[FLAG_Z]);
      end
      op_compare_regs_with_carry:
      begin
        is_cmp = 1'b1;
        cmp_res = cmp_flags(rd_val, rr_val, sf[FLAG_C], 1'b1, sf[FLAG_Z]);
      end
      op_compare_immediate:
      begin
        is_cmp = 1'b1;
        cmp_res = cmp_flags(rd_val, rr_val, 1'b0, 1'b0, sf[FLAG_Z]);
      end
      op_skip_reg_bit_clear:
      begin
        is_skip = 1'b1;
        take = ~rr_val[bit_sel];
      end
      op_skip_reg_bit_set:
      begin
        is_skip = 1'b1;
        take = rr_val[bit_sel];
      end
      op_skip_io_bit_clear:
      begin
        is_skip = 1'b1;
        take = ~io_val[bit_sel];
      end
      op_skip_io_bit_set:
      begin
        is_skip = 1'b1;
        take = io_val[bit_sel];
      end
      op_branch_flag_set: take = sf[bit_sel];
      op_branch_flag_clear: take = ~sf[bit_sel];
      op_branch_equal: take = sf[FLAG_Z];
      op_branch_carry_clear: take = ~sf[FLAG_C];
      op_branch_same_or_higher: take = ~sf[FLAG_C];
      op_branch_minus: take = sf[FLAG_N];
      op_branch_signed_ge: take = ~(sf[FLAG_N] ^ sf[FLAG_V]);
      op_branch_signed_lt: take = sf[FLAG_N] ^ sf[FLAG_V];
      op_branch_halfcarry_set: take = sf[FLAG_H];
      op_branch_halfcarry_clear: take = ~sf[FLAG_H];
      op_branch_bitcopy_set: take = sf[FLAG_T];
      op_call_direct, op_subroutine_return, op_interrupt_return:
      begin
        take = 1'b1;
      end
      op_none:
      begin
        take = 1'b0;
      end
      default:
      begin
        take = 1'b0;
      end
    endcase
  end

  // destination and length; a not-taken instruction simply steps on
  always_comb
  begin
    dest = pc + PC_W'(PC_STEP_NEXT);
    cycles = CYC_ONE;
    if (is_skip && take)
    begin
      dest = skip_target(pc, next_two_word);
      cycles = next_two_word ? CYC_THREE : CYC_TWO;
    end
    else if (is_branch && take)
    begin
      dest = rel_target(pc, offset);
      cycles = CYC_TWO;
    end
    else if (op == op_call_direct)
    begin
      dest = target;
      cycles = CYC_STACK;
    end
    else if (op == op_subroutine_return || op == op_interrupt_return)
    begin
      dest = pc; // replaced by the popped address
      cycles = CYC_STACK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  flow_state_t state_ff, nxt_state;
  logic [2:0] cnt_ff, nxt_cnt;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic pc_load_ff, nxt_pc_load;
  logic [PC_W-1:0] next_pc_ff, nxt_next_pc;
  logic flags_wr_ff, nxt_flags_wr;
  logic [7:0] flags_mask_ff, nxt_flags_mask;
  logic [7:0] flags_out_ff, nxt_flags_out;
  logic push_ff, nxt_push;
  logic [PC_W-1:0] push_data_ff, nxt_push_data;
  logic pop_ff, nxt_pop;
  logic returning_ff, nxt_returning;

  // issue is ignored while busy; multi-cycle work counts down to done
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_pc_load = pc_load_ff;
    nxt_next_pc = next_pc_ff;
    nxt_flags_wr = 1'b0;
    nxt_flags_mask = flags_mask_ff;
    nxt_flags_out = flags_out_ff;
    nxt_push = 1'b0;
    nxt_push_data = push_data_ff;
    nxt_pop = 1'b0;
    nxt_returning = returning_ff;
    unique case (state_ff)
      st_idle:
      begin
        if (issue && op != op_none)
        begin
          nxt_next_pc = dest;
          nxt_pc_load = take && !is_cmp;
          nxt_returning = (op == op_subroutine_return || op == op_interrupt_return);
          if (is_cmp)
          begin
            nxt_flags_wr = 1'b1;
            nxt_flags_mask = CMP_FLAG_MASK;
            nxt_flags_out = cmp_res;
          end
          if (op == op_call_direct)
          begin
            nxt_push = 1'b1;
            nxt_push_data = pc + PC_W'(PC_STEP_CALL);
          end
          if (nxt_returning)
          begin
            nxt_pop = 1'b1;
          end
          if (cycles == CYC_ONE)
          begin
            nxt_done = 1'b1;
          end
          else
          begin
            nxt_busy = 1'b1;
            nxt_cnt = cycles - CYC_ONE;
            nxt_state = st_busy;
          end
        end
      end
      st_busy:
      begin
        // stack answers while the pop strobe stands
        if (returning_ff && cnt_ff == POP_SAMPLE_CNT)
        begin
          nxt_next_pc = pop_data;
        end
        nxt_cnt = cnt_ff - CYC_ONE;
        if (cnt_ff == CYC_ONE)
        begin
          nxt_done = 1'b1;
          nxt_busy = 1'b0;
          nxt_returning = 1'b0;
          nxt_state = st_idle;
        end
      end
    endcase
  end

  // registers only
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_ff <= st_idle;
      cnt_ff <= 3'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      pc_load_ff <= 1'b0;
      next_pc_ff <= '0;
      flags_wr_ff <= 1'b0;
      flags_mask_ff <= FLAGS_RESET;
      flags_out_ff <= FLAGS_RESET;
      push_ff <= 1'b0;
      push_data_ff <= '0;
      pop_ff <= 1'b0;
      returning_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      pc_load_ff <= nxt_pc_load;
      next_pc_ff <= nxt_next_pc;
      flags_wr_ff <= nxt_flags_wr;
      flags_mask_ff <= nxt_flags_mask;
      flags_out_ff <= nxt_flags_out;
      push_ff <= nxt_push;
      push_data_ff <= nxt_push_data;
      pop_ff <= nxt_pop;
      returning_ff <= nxt_returning;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flip-flop

  assign busy = busy_ff;
  assign done = done_ff;
  assign pc_load = pc_load_ff;
  assign next_pc = next_pc_ff;
  assign flags_wr = flags_wr_ff;
  assign flags_mask = flags_mask_ff;
  assign flags_out = flags_out_ff;
  assign push = push_ff;
  assign push_data = push_data_ff;
  assign pop = pop_ff;

endmodule

/* File: pkg/flow_pkg.sv */
// constants and types for the compare, skip and branch execution unit
// assumes an 8-bit core with a status byte laid out as below
package flow_pkg;

  // status byte bit positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // widths fixed by the instruction set
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BIT_SEL_W = 3;
  localparam int unsigned OFFSET_W = 7;

  // flags written by the compare group
  localparam logic [7:0] CMP_FLAG_MASK = 8'h2f;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // cycle counts per instruction
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_STACK = 3'h4;

  // remaining-count value at which a return samples the popped address
  localparam logic [2:0] POP_SAMPLE_CNT = 3'h3;

  // program counter steps
  localparam int unsigned PC_STEP_NEXT = 1;
  localparam int unsigned PC_STEP_SKIP1 = 2;
  localparam int unsigned PC_STEP_SKIP2 = 3;
  localparam int unsigned PC_STEP_CALL = 2;

  // operations handed over by the instruction decoder
  typedef enum logic [4:0] {
    op_none,
    op_compare_skip_equal,
    op_compare_regs,
    op_compare_regs_with_carry,
    op_compare_immediate,
    op_skip_reg_bit_clear,
    op_skip_reg_bit_set,
    op_skip_io_bit_clear,
    op_skip_io_bit_set,
    op_branch_flag_set,
    op_branch_flag_clear,
    op_branch_equal,
    op_branch_carry_clear,
    op_branch_same_or_higher,
    op_branch_minus,
    op_branch_signed_ge,
    op_branch_signed_lt,
    op_branch_halfcarry_set,
    op_branch_halfcarry_clear,
    op_branch_bitcopy_set,
    op_call_direct,
    op_subroutine_return,
    op_interrupt_return
  } flow_op_t;

  typedef enum logic {
    st_idle,
    st_busy
  } flow_state_t;

endpackage

/* File: test/branch_compare_skip_unit_bench.sv */
// self-checking bench for the compare, skip and branch unit
// assumes the unit and its property checker are compiled alongside
`timescale 1ns/10ps
module branch_compare_skip_unit_bench;
  import flow_pkg::*;

  logic clock = 1'b0;
  logic srst = 1'b1;
  logic issue = 1'b0;
  flow_op_t op = op_none;
  logic [15:0] pc = 16'h0100;
  logic [7:0] rd_val = 8'h00;
  logic [7:0] rr_val = 8'h00;
  logic [7:0] io_val = 8'h00;
  logic [2:0] bit_sel = 3'h6;
  logic [6:0] offset = 7'h7e;
  logic [15:0] target = 16'h1234;
  logic next_two_word = 1'b0;
  logic [7:0] status_flags_register = 8'h00;
  logic [15:0] pop_data = 16'h0456;
  logic busy, done, pc_load, flags_wr, push, pop;
  logic [15:0] next_pc, push_data;
  logic [7:0] flags_mask, flags_out;
  int err_total = 0;
  int n_checks = 0;
  int push_at, pop_at;
  logic [15:0] pd;

  branch_compare_skip_unit #(.PC_W(16)) dut (.clock, .srst, .issue, .op, .pc, .rd_val, .rr_val, .io_val,
    .bit_sel, .offset, .target, .next_two_word, .status_flags_register, .pop_data, .busy, .done, .pc_load,
    .next_pc, .flags_wr, .flags_mask, .flags_out, .push, .push_data, .pop);

  initial
  begin
    forever #25 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] r, input logic [7:0] s, input logic tw);
    rd_val = a;
    rr_val = r;
    io_val = a;
    status_flags_register = s;
    next_two_word = tw;
  endtask

  // one issue, cycles counted to done; an idle edge first, so issue never drops and rises in one step
  task automatic go(input flow_op_t o, input int ncyc, input logic ld, input logic [15:0] epc);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    push_at = 0;
    pop_at = 0;
    op = o;
    issue = 1'b1;
    do
    begin
      @(posedge clock);
      #1;
      issue = 1'b0;
      n++;
      if (push === 1'b1)
      begin
        push_at = n;
        pd = push_data;
      end
      if (pop === 1'b1)
        pop_at = n;
    end
    while (done !== 1'b1 && n < 8);
    chk(n, ncyc);
    chk(pc_load, ld);
    chk(next_pc, epc);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_compare();
    put(8'h10, 8'h20, 8'h00, 1'b0);
    go(op_compare_regs, 1, 1'b0, 16'h0101);
    chk({flags_wr, flags_mask, flags_out & flags_mask}, {1'b1, 8'h2f, 8'h05});
    put(8'h80, 8'h00, 8'h01, 1'b0);
    go(op_compare_regs_with_carry, 1, 1'b0, 16'h0101);
    chk(flags_out & flags_mask, 8'h28);
    put(8'h33, 8'h33, 8'h00, 1'b0);
    go(op_compare_immediate, 1, 1'b0, 16'h0101);
    chk(flags_out & flags_mask, 8'h02);
    $display("compare test done");
  endtask

  task automatic t_skip_equal();
    put(8'h5a, 8'h5a, 8'h00, 1'b0);
    go(op_compare_skip_equal, 2, 1'b1, 16'h0102);
    put(8'h5a, 8'h5a, 8'h00, 1'b1);
    go(op_compare_skip_equal, 3, 1'b1, 16'h0103);
    put(8'h5a, 8'h5b, 8'h00, 1'b1);
    go(op_compare_skip_equal, 1, 1'b0, 16'h0101);
    $display("compare skip test done");
  endtask

  // other bits set opposite to the chosen one, so a wrong bit index shows
  task automatic t_skips();
    flow_op_t sk[4] = '{op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear, op_skip_io_bit_set};
    logic [7:0] v;
    int hit;
    for (int i = 0; i < 4; i++)
      for (int b = 0; b < 2; b++)
      begin
        v = b ? 8'h40 : 8'hbf;
        hit = (b == i % 2) ? 2 + i / 2 : 1;
        put(v, v, 8'h00, 1'(i / 2));
        go(sk[i], hit, 1'(hit > 1), 16'h0100 + 16'(hit));
      end
    $display("skip test done");
  endtask

  task automatic t_branches();
    flow_op_t bo[11] = '{op_branch_flag_set, op_branch_flag_clear, op_branch_equal, op_branch_carry_clear,
      op_branch_same_or_higher, op_branch_minus, op_branch_signed_ge, op_branch_signed_lt,
      op_branch_halfcarry_set, op_branch_halfcarry_clear, op_branch_bitcopy_set};
    logic [7:0] yes[11] = '{8'h40, 8'h00, 8'h02, 8'h00, 8'h00, 8'h04, 8'h0c, 8'h08, 8'h20, 8'h00, 8'h40};
    logic [7:0] no[11] = '{8'h00, 8'h40, 8'h00, 8'h01, 8'h01, 8'h00, 8'h04, 8'h0c, 8'h00, 8'h20, 8'h00};
    for (int k = 0; k < 2; k++)
    begin
      offset = k ? 7'h3f : 7'h7e;
      for (int i = 0; i < 11; i++)
      begin
        put(8'h00, 8'h00, yes[i], 1'b0);
        go(bo[i], 2, 1'b1, k ? 16'h0140 : 16'h00ff);
        put(8'h00, 8'h00, no[i], 1'b0);
        go(bo[i], 1, 1'b0, 16'h0101);
      end
    end
    $display("branch test done");
  endtask

  task automatic t_flow();
    pc = 16'h0200;
    go(op_call_direct, 4, 1'b1, 16'h1234);
    chk(push_at, 1);
    chk(pd, 16'h0202);
    go(op_subroutine_return, 4, 1'b1, 16'h0456);
    chk(pop_at, 1);
    pop_data = 16'h0789;
    go(op_interrupt_return, 4, 1'b1, 16'h0789);
    chk(pop_at, 1);
    $display("call and return test done");
  endtask

  // a reset in the middle of a call drops the sequence and leaves every output low
  task automatic t_reset_mid();
    @(posedge clock);
    #1;
    pc = 16'h0300;
    op = op_call_direct;
    issue = 1'b1;
    @(posedge clock);
    #1;
    issue = 1'b0;
    srst = 1'b1;
    chk({busy, push}, 2'h3);
    @(posedge clock);
    #1;
    srst = 1'b0;
    chk({busy, done, pc_load, flags_wr, push, pop, next_pc}, 22'h0);
    @(posedge clock);
    #1;
    chk({busy, done, pc_load, flags_wr, push, pop, next_pc}, 22'h0);
    put(8'h10, 8'h20, 8'h00, 1'b0);
    go(op_compare_regs, 1, 1'b0, 16'h0301);
    chk(flags_out & flags_mask, 8'h05);
    $display("reset in flight test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clock);
    #1;
    srst = 1'b0;
    @(posedge clock);
    #1;
    chk({busy, done, pc_load, flags_wr, push, pop, next_pc}, 22'h0);
    $display("reset test done");
    t_compare();
    t_skip_equal();
    t_skips();
    t_branches();
    t_flow();
    t_reset_mid();
    wrap_up();
  end

  // the whole sequence needs under two hundred cycles; this is far beyond it
  initial
  begin
    repeat (5000) @(posedge clock);
    err_total++;
    wrap_up();
  end
endmodule

bind branch_compare_skip_unit branch_compare_skip_unit_properties #(.PC_W(PC_W)) props (.clock, .srst, .issue,
  .op, .pc, .rd_val, .rr_val, .io_val, .bit_sel, .offset, .next_two_word, .status_flags_register, .busy, .done,
  .pc_load, .next_pc, .flags_wr, .flags_mask, .push, .push_data, .pop);

/* File: test/branch_compare_skip_unit_properties.sv */
// port-level assertions for the compare, skip and branch unit
// assumes it is bound to the unit from the bench; one clock, srst high resets
`timescale 1ns/10ps
module branch_compare_skip_unit_properties
#(
  parameter int unsigned PC_W = 16
)
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // decoder side
  input wire logic issue,
  input wire flow_pkg::flow_op_t op,
  input wire logic [PC_W-1:0] pc,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic [7:0] io_val,
  input wire logic [2:0] bit_sel,
  input wire logic [6:0] offset,
  input wire logic next_two_word,
  input wire logic [7:0] status_flags_register,
  // results
  input wire logic busy,
  input wire logic done,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] next_pc,
  input wire logic flags_wr,
  input wire logic [7:0] flags_mask,
  input wire logic push,
  input wire logic [PC_W-1:0] push_data,
  input wire logic pop
);
  import flow_pkg::*;

  logic start;
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] nxt_pc_ff;
  logic [PC_W-1:0] tgt_ff;
  logic [PC_W-1:0] nxt_tgt;

  // pc and branch target held from issue, since inputs move on while busy
  assign start = issue && !busy;
  always_comb
  begin
    nxt_pc_ff = pc_ff;
    nxt_tgt = tgt_ff;
    if (start)
    begin
      nxt_pc_ff = pc;
      nxt_tgt = pc + {{(PC_W-7){offset[6]}}, offset} + PC_W'(1);
    end
  end
  always_ff @(posedge clock)
  begin
    pc_ff <= srst ? '0 : nxt_pc_ff;
    tgt_ff <= srst ? '0 : nxt_tgt;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // shared sequences
  sequence taken_s;
    busy ##1 (done && !busy && pc_load && next_pc == tgt_ff);
  endsequence
  sequence quick_s;
    done && !busy && !pc_load && next_pc == pc_ff + PC_W'(1);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  cmp_flags_a:
    assert property (start && op inside {op_compare_regs, op_compare_regs_with_carry, op_compare_immediate}
      |=> quick_s and (flags_wr && flags_mask == CMP_FLAG_MASK)) else $error("compare result wrong");
  flag_pulse_a:
    assert property (flags_wr |-> done ##1 !flags_wr || done) else $error("flag write out of place");
  skip_equal_long_a:
    assert property (start && op == op_compare_skip_equal && rd_val == rr_val && next_two_word
      |=> busy [*2] ##1 (done && pc_load && next_pc == pc_ff + PC_W'(3))) else $error("long skip wrong");
  skip_equal_miss_a:
    assert property (start && op == op_compare_skip_equal && rd_val != rr_val |=> quick_s)
      else $error("unequal compare skipped");
  io_skip_a:
    assert property (start && op == op_skip_io_bit_set && io_val[bit_sel] && next_two_word
      |=> busy [*2] ##1 (done && next_pc == pc_ff + PC_W'(3))) else $error("io skip wrong");
  beq_taken_a:
    assert property (start && op == op_branch_equal && status_flags_register[FLAG_Z] |=> taken_s)
      else $error("equal branch not taken");
  beq_miss_a:
    assert property (start && op == op_branch_equal && !status_flags_register[FLAG_Z] |=> quick_s)
      else $error("equal branch taken wrongly");
  bcc_taken_a:
    assert property (start && op == op_branch_carry_clear && !status_flags_register[FLAG_C] |=> taken_s)
      else $error("carry clear branch wrong");
  blt_taken_a:
    assert property (start && op == op_branch_signed_lt
      && (status_flags_register[FLAG_N] ^ status_flags_register[FLAG_V]) |=> taken_s) else $error("lt branch wrong");
  call_push_a:
    assert property (start && op == op_call_direct |=> (push && busy && push_data == pc_ff + PC_W'(2))
      ##1 (busy && !push) [*2] ##1 (done && !busy)) else $error("call sequence wrong");
  return_pop_a:
    assert property (start && op inside {op_subroutine_return, op_interrupt_return}
      |=> (pop && busy) ##1 !pop ##2 (done && pc_load)) else $error("return sequence wrong");
endmodule
